// file: scrp_pkg.sv
/*
 * shared constants and types of the serial command register port:
 * register map, field layout, frame counts, timing and state codes.
 * assumes a 50 MHz system clock at both ends.
 */
`default_nettype none
package scrp_pkg;
    // ************************************************
    // device register map
    // ************************************************
    localparam int NUM_CHAN = 3;
    localparam logic [4:0] CFG_ADDR [NUM_CHAN] = '{5'h06, 5'h0e, 5'h16};
    localparam logic [4:0] STAT_ADDR [NUM_CHAN] = '{5'h07, 5'h0f, 5'h17};
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam int CFG_BUFFER_SIZE_SELECT = 0;
    localparam int CFG_CLOCK_EDGE_SELECT = 1;
    localparam int CFG_BANDWIDTH_SELECT = 2;
    localparam int CFG_ATTENUATOR_DISABLE = 3;
    localparam int CFG_RATE_E_OR_D_SELECT = 4;
    localparam int CFG_RATE_SONET_SELECT = 5;
    localparam int STAT_FLAG_BIT = 0;
    // ************************************************
    // frame layout, counted in rising serial clock edges
    // ************************************************
    localparam int OP_BIT = 0;
    localparam int ADDR_LSB = 1;
    localparam int ADDR_MSB = 5;
    localparam logic [4:0] CNT_ADDR_END = 5'h06;
    localparam logic [4:0] CNT_HDR_LAST = 5'h07;
    localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
    localparam logic [4:0] CNT_FRAME = 5'h10;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int CS_SETUP_NS = 50;
    localparam int CS_SETUP_CYC =
        (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_NS = 160;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
    // ************************************************
    // controller register map
    // ************************************************
    localparam logic [2:0] H_CMD = 3'h0;
    localparam logic [2:0] H_WDATA = 3'h1;
    localparam logic [2:0] H_RDATA = 3'h2;
    localparam logic [2:0] H_STATUS = 3'h3;
    localparam logic [2:0] H_IRQ_STAT = 3'h4;
    localparam logic [2:0] H_IRQ_MASK = 3'h5;
    localparam int CMD_RW_BIT = 5;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    // ************************************************
    // states
    // ************************************************
    typedef enum logic [1:0] {
        DEV_HDR = 2'b00,
        DEV_READ = 2'b01,
        DEV_WRITE = 2'b10,
        DEV_DONE = 2'b11
    } scrp_dev_state_type;
    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_SETUP = 2'b01,
        HST_HIGH = 2'b10,
        HST_LOW = 2'b11
    } scrp_hst_state_type;
endpackage : scrp_pkg
`default_nettype wire

// file: scrp_if.sv
/*
 * four-wire serial link between controller and device.
 * assumes no pull on the shared data wire: once released it reads as
 * the inverse of the last bit driven, so a late sample shows up.
 */
`timescale 1ns/1ps
`default_nettype none
interface scrp_if;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic serial_out_line;
    // what the controller sees on the wire that the device may release
    assign serial_out_line = serial_out_oe ? serial_out : ~serial_out;
    modport ctrl (output sclk, output cs_n, output serial_in,
        input serial_out_line);
    modport dev (input sclk, input cs_n, input serial_in,
        output serial_out, output serial_out_oe);
endinterface : scrp_if
`default_nettype wire

// file: scrp_sync.sv
/*
 * two-flop synchroniser with edge pulses on the synchronised level.
 * assumes inputs are asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module scrp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // asynchronous in, synchronous out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // edges come from stages two and three, never from stage one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_o = s2_q;
    assign rise_o = s2_q & ~s3_q;
    assign fall_o = ~s2_q & s3_q;
endmodule : scrp_sync
`default_nettype wire

// file: scrp_device.sv
/*
 * device end of the serial command register port: frame decoder,
 * per-channel configuration registers and status readback.
 * assumes serial clock, select and data arrive asynchronously and
 * that each level lasts several clk_i cycles.
 */
// Notes on behaviour
// - host asserts select 60 ns (three clocks) before first rise
// - first sampled bit: one reads, zero writes
// - five address bits follow, lsb first
// - host sends seventh header bit as zero
// - eighth header bit is ignored
// - read output enabled on falling edge eight
// - read byte shifted lsb first on falling edges
// - host samples read bits on next rise
// - two idle periods follow the address
// - write byte captured on rises nine onward
// - output released whenever not driving read data
// - config holds six fields, top two unused
// - status reports flag in bit zero
// - mode pin low disables port, pins configure
`timescale 1ns/1ps
`default_nettype none
module scrp_device (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial link
    scrp_if.dev link,
    // mode and hardware configuration pins
    input wire logic host_mode_select_i,
    input wire logic [5:0] hw_config_i,
    // per-channel status in, configuration out
    input wire logic [scrp_pkg::NUM_CHAN-1:0] status_flag_i,
    output logic [scrp_pkg::NUM_CHAN-1:0][5:0] chan_config_o
);
    localparam int NCH = scrp_pkg::NUM_CHAN;

    // ************************************************
    // synchronisers
    // ************************************************
    logic [2:0] link_lvl;
    logic [2:0] link_rise;
    logic [2:0] link_fall;
    logic [6:0] pin_lvl;

    scrp_sync #(
        .W(3),
        .INIT(3'h2)
    ) u_link_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({link.serial_in, link.cs_n, link.sclk}),
        .lvl_o(link_lvl),
        .rise_o(link_rise),
        .fall_o(link_fall)
    );

    scrp_sync #(
        .W(7),
        .INIT(7'h00)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({host_mode_select_i, hw_config_i}),
        .lvl_o(pin_lvl),
        .rise_o(),
        .fall_o()
    );

    wire host_mode = pin_lvl[6];
    wire [5:0] hw_cfg = pin_lvl[5:0];
    wire sclk_rise = link_rise[0];
    wire sclk_fall = link_fall[0];
    wire serial_in_s = link_lvl[2];
    // serial port only listens in host mode
    wire cs_act = ~link_lvl[1] & host_mode;

    // ************************************************
    // frame state
    // ************************************************
    scrp_pkg::scrp_dev_state_type state_q;
    logic [4:0] cnt_q;
    logic [5:0] hdr_q;
    logic [7:0] wsh_q;
    logic [7:0] rd_q;
    logic serial_out_q;
    logic oe_q;
    logic [5:0] cfg_q [NCH];
    logic [7:0] rd_mux;
    logic [NCH-1:0][7:0] rd_part;

    // five address bits only; header bits seven and eight never decode
    wire [4:0] addr_w = hdr_q[scrp_pkg::ADDR_MSB:scrp_pkg::ADDR_LSB];
    wire hdr_bit_store = cnt_q < scrp_pkg::CNT_ADDR_END;
    wire op_read = hdr_q[scrp_pkg::OP_BIT];
    wire hdr_last = cnt_q == scrp_pkg::CNT_HDR_LAST;
    wire data_last = cnt_q == scrp_pkg::CNT_DATA_LAST;
    wire frame_end = cnt_q == scrp_pkg::CNT_FRAME;
    wire wr_commit = cs_act & sclk_rise & data_last &
        (state_q == scrp_pkg::DEV_WRITE);
    wire [7:0] wr_byte = {serial_in_s, wsh_q[6:0]};

    // ************************************************
    // register decode
    // ************************************************
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_chan
            wire cfg_hit = addr_w == scrp_pkg::CFG_ADDR[c];
            wire stat_hit = addr_w == scrp_pkg::STAT_ADDR[c];
            // top two config bits and top seven status bits read zero
            assign rd_part[c] = cfg_hit ? {2'b00, cfg_q[c]} :
                stat_hit ? {7'h00, status_flag_i[c]} :
                8'h00;

            // only a completed write to a config address lands
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cfg_q[c] <= scrp_pkg::CFG_RESET;
                end else if (!host_mode) begin
                    cfg_q[c] <= hw_cfg;
                end else if (wr_commit && cfg_hit) begin
                    cfg_q[c] <= wr_byte[5:0];
                end
            end

            assign chan_config_o[c] = cfg_q[c];
        end
    endgenerate

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NCH; i++) begin
            rd_mux = rd_mux | rd_part[i];
        end
    end

    // ************************************************
    // frame sequencer
    // ************************************************
    // the byte is snapshot at header end so a status change mid-read
    // cannot tear the word the host sees
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= scrp_pkg::DEV_HDR;
            cnt_q <= 5'h00;
            hdr_q <= 6'h00;
            wsh_q <= 8'h00;
            rd_q <= 8'h00;
            serial_out_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!cs_act) begin
            state_q <= scrp_pkg::DEV_HDR;
            cnt_q <= 5'h00;
            oe_q <= 1'b0;
        end else if (sclk_rise) begin
            if (!frame_end) begin
                cnt_q <= cnt_q + 5'h01;
            end
            case (state_q)
                scrp_pkg::DEV_HDR: begin
                    if (hdr_bit_store) begin
                        hdr_q[cnt_q[2:0]] <= serial_in_s;
                    end
                    // bits seven and eight pass unchecked
                    if (hdr_last) begin
                        rd_q <= rd_mux;
                        state_q <= op_read ? scrp_pkg::DEV_READ :
                            scrp_pkg::DEV_WRITE;
                    end
                end
                scrp_pkg::DEV_WRITE: begin
                    // edges 7 and 8 were the idle gap
                    wsh_q[cnt_q[2:0]] <= serial_in_s;
                    if (data_last) begin
                        state_q <= scrp_pkg::DEV_DONE;
                    end
                end
                scrp_pkg::DEV_READ: begin
                end
                scrp_pkg::DEV_DONE: begin
                end
                default: begin
                    state_q <= scrp_pkg::DEV_DONE;
                end
            endcase
        end else if (sclk_fall && state_q == scrp_pkg::DEV_READ) begin
            if (frame_end) begin
                oe_q <= 1'b0;
                state_q <= scrp_pkg::DEV_DONE;
            end else begin
                // first fall in read is the fall of cycle 8
                serial_out_q <= rd_q[cnt_q[2:0]];
                oe_q <= 1'b1;
            end
        end
    end

    // ************************************************
    // link outputs
    // ************************************************
    assign link.serial_out = serial_out_q;
    assign link.serial_out_oe = oe_q;
endmodule : scrp_device
`default_nettype wire

// file: scrp_host.sv
/*
 * controller end of the serial command register port: makes the
 * serial clock by division, frames one transfer per command.
 * assumes a plain register port on clk_i with read data one cycle
 * after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module scrp_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial link
    scrp_if.ctrl link,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // interrupt
    output logic irq_o
);
    localparam logic [3:0] SETUP_LOAD = 4'(scrp_pkg::CS_SETUP_CYC - 1);
    localparam logic [3:0] HALF_LOAD = 4'(scrp_pkg::SCLK_HALF_CYC - 1);

    logic serial_out_s;

    scrp_sync #(
        .W(1),
        .INIT(1'b0)
    ) u_serial_out_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(link.serial_out_line),
        .lvl_o(serial_out_s),
        .rise_o(),
        .fall_o()
    );

    // ************************************************
    // registers
    // ************************************************
    scrp_pkg::scrp_hst_state_type state_q;
    logic [3:0] timer_q;
    logic [4:0] bit_q;
    logic [16:0] frame_q;
    logic rw_q;
    logic [7:0] wdata_q;
    logic [7:0] rsh_q;
    logic [7:0] rres_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [7:0] rdata_q;
    logic sclk_q;
    logic cs_n_q;
    logic serial_in_q;

    wire busy = state_q != scrp_pkg::HST_IDLE;
    wire tick = timer_q == 4'h0;
    wire cmd_wr = wr_i && addr_i == scrp_pkg::H_CMD;
    wire start = cmd_wr && !busy;
    wire refused = cmd_wr && busy;
    wire cmd_rw = wdata_i[scrp_pkg::CMD_RW_BIT];
    // header: op, five address bits lsb first, two zero bits
    wire [16:0] frame_d = {1'b0, cmd_rw ? 8'h00 : wdata_q, 2'b00,
        wdata_i[4:0], cmd_rw};
    wire last_low = bit_q == scrp_pkg::CNT_FRAME;
    wire data_bit = bit_q > scrp_pkg::CNT_HDR_LAST;
    wire done = state_q == scrp_pkg::HST_LOW && tick && last_low;
    wire [1:0] events = {refused, done};
    wire [1:0] clr = (wr_i && addr_i == scrp_pkg::H_IRQ_STAT) ?
        wdata_i[1:0] : 2'b00;
    wire [7:0] rd_sel =
        (addr_i == scrp_pkg::H_WDATA) ? wdata_q :
        (addr_i == scrp_pkg::H_RDATA) ? rres_q :
        (addr_i == scrp_pkg::H_STATUS) ? {7'h00, busy} :
        (addr_i == scrp_pkg::H_IRQ_STAT) ? {6'h00, stat_q} :
        (addr_i == scrp_pkg::H_IRQ_MASK) ? {6'h00, mask_q} : 8'h00;

    // ************************************************
    // register port and interrupt
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdata_q <= 8'h00;
            mask_q <= 2'b00;
            stat_q <= 2'b00;
            rdata_q <= 8'h00;
        end else begin
            if (wr_i && addr_i == scrp_pkg::H_WDATA) begin
                wdata_q <= wdata_i;
            end
            if (wr_i && addr_i == scrp_pkg::H_IRQ_MASK) begin
                mask_q <= wdata_i[1:0];
            end
            // a new event beats a clear in the same cycle
            stat_q <= (stat_q & ~clr) | events;
            rdata_q <= rd_i ? rd_sel : 8'h00;
        end
    end

    // ************************************************
    // serial sequencer
    // ************************************************
    // the divider runs only inside a frame; sclk idles low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= scrp_pkg::HST_IDLE;
            timer_q <= 4'h0;
            bit_q <= 5'h00;
            frame_q <= 17'h0_0000;
            rw_q <= 1'b0;
            rsh_q <= 8'h00;
            rres_q <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            serial_in_q <= 1'b0;
        end else begin
            timer_q <= tick ? 4'h0 : timer_q - 4'h1;
            case (state_q)
                scrp_pkg::HST_IDLE: begin
                    if (start) begin
                        cs_n_q <= 1'b0;
                        frame_q <= frame_d;
                        rw_q <= cmd_rw;
                        serial_in_q <= frame_d[0];
                        bit_q <= 5'h00;
                        timer_q <= SETUP_LOAD;
                        state_q <= scrp_pkg::HST_SETUP;
                    end
                end
                scrp_pkg::HST_SETUP: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        timer_q <= HALF_LOAD;
                        state_q <= scrp_pkg::HST_HIGH;
                    end
                end
                scrp_pkg::HST_HIGH: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        bit_q <= bit_q + 5'h01;
                        serial_in_q <= frame_q[bit_q + 5'h01];
                        timer_q <= HALF_LOAD;
                        state_q <= scrp_pkg::HST_LOW;
                    end
                end
                scrp_pkg::HST_LOW: begin
                    if (tick && last_low) begin
                        cs_n_q <= 1'b1;
                        if (rw_q) begin
                            rres_q <= rsh_q;
                        end
                        state_q <= scrp_pkg::HST_IDLE;
                    end else if (tick) begin
                        sclk_q <= 1'b1;
                        if (rw_q && data_bit) begin
                            rsh_q[bit_q[2:0]] <= serial_out_s;
                        end
                        timer_q <= HALF_LOAD;
                        state_q <= scrp_pkg::HST_HIGH;
                    end
                end
                default: begin
                    state_q <= scrp_pkg::HST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.serial_in = serial_in_q;
    assign rdata_o = rdata_q;
    assign irq_o = |(stat_q & mask_q);
endmodule : scrp_host
`default_nettype wire

// file: scrp_checker.sv
/*
 * concurrent checks on the serial link between the two ends.
 * assumes sclk is made from clk_i by the host end, so it is
 * sampled on clk_i directly without a synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module scrp_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ************************************************
    // rise counter and operation bit of the frame
    // ************************************************
    logic sclk_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic op_q;
    logic op_d;
    wire logic rise;
    assign rise = sclk & ~sclk_q;
    assign cnt_d = cs_n ? 5'h00 : cnt_q + {4'h0, rise};
    assign op_d = (rise && cnt_q == 5'h00) ? serial_in : op_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
            cnt_q <= 5'h00;
            op_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            cnt_q <= cnt_d;
            op_q <= op_d;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ************************************************
    // assertions
    // ************************************************
    property p_cs_setup;
        $fell(cs_n) |-> !sclk [*3];
    endproperty
    a_cs_setup: assert property (p_cs_setup)
        else $error("select setup before first rise too short");
    property p_sclk_idle;
        cs_n |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock moves outside a frame");
    property p_sclk_half;
        $rose(sclk) |-> sclk [*8] ##1 !sclk;
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("serial clock high phase not 8 cycles");
    property p_hdr_zero;
        rise && cnt_q == 5'h06 |-> !serial_in;
    endproperty
    a_hdr_zero: assert property (p_hdr_zero)
        else $error("seventh header bit not zero");
    property p_oe_start;
        $rose(serial_out_oe) |-> op_q && cnt_q == 5'h08 && !sclk;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("output enabled outside read cycle 8");
    property p_oe_write;
        !cs_n && cnt_q != 5'h00 && !op_q |-> !serial_out_oe;
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("output enabled during a write");
    property p_oe_end;
        $fell(sclk) && cnt_q == 5'h10 |-> ##[1:5] !serial_out_oe;
    endproperty
    a_oe_end: assert property (p_oe_end)
        else $error("output not released after last bit");
    property p_cs_idle;
        cs_n [*5] |-> !serial_out_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("output driven while deselected");
    property p_out_hold;
        rise && serial_out_oe |-> $stable(serial_out) [*7];
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("read bit changes while clock high");
    property p_frame_len;
        $rose(cs_n) |-> cnt_q == 5'h10;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame not 16 rising edges");
endmodule : scrp_checker
`default_nettype wire

// file: tb_serial_command_register_port.sv
/*
 * self-checking bench: host and device joined by the link.
 * assumes host register port and device pins on one 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_command_register_port;
    localparam logic [7:0] PAT [3] = '{8'he5, 8'h1a, 8'h6b};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic host_mode_select_i = 1'b1;
    logic [5:0] hw_config_i = 6'h00;
    logic [scrp_pkg::NUM_CHAN-1:0] status_flag_i = '0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic [scrp_pkg::NUM_CHAN-1:0][5:0] chan_config_o;
    int mismatches = 0;
    int cmp_count = 0;
    always #10 clk_i = ~clk_i;
    scrp_if i_scrp_if ();
    scrp_host i_scrp_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(i_scrp_if), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    scrp_device i_scrp_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(i_scrp_if), .host_mode_select_i(host_mode_select_i),
        .hw_config_i(hw_config_i), .status_flag_i(status_flag_i),
        .chan_config_o(chan_config_o));
    scrp_checker i_scrp_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk(i_scrp_if.sclk), .cs_n(i_scrp_if.cs_n),
        .serial_in(i_scrp_if.serial_in),
        .serial_out(i_scrp_if.serial_out),
        .serial_out_oe(i_scrp_if.serial_out_oe));
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic wait_idle;
        logic [7:0] s;
        s = 8'h01;
        for (int n = 0; n < 400 && s[0] !== 1'b0; n++)
            rd(scrp_pkg::H_STATUS, s);
        chk("busy", s, 8'h00);
    endtask : wait_idle
    task automatic xfer(input logic rw, input logic [4:0] a,
        input logic [7:0] d, output logic [7:0] q);
        wr(scrp_pkg::H_WDATA, d);
        wr(scrp_pkg::H_CMD, {2'b00, rw, a});
        wait_idle();
        q = 8'h00;
        if (rw)
            rd(scrp_pkg::H_RDATA, q);
    endtask : xfer
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset;
        logic [7:0] q;
        for (int c = 0; c < 3; c++) begin
            xfer(1'b1, scrp_pkg::CFG_ADDR[c], 8'h00, q);
            chk("cfg_reset", q, {2'b00, scrp_pkg::CFG_RESET});
            chk("cfg_out", {2'b00, chan_config_o[c]}, 8'h00);
        end
    endtask : t_reset
    task automatic t_cfg;
        logic [7:0] q;
        for (int c = 0; c < 3; c++)
            xfer(1'b0, scrp_pkg::CFG_ADDR[c], PAT[c], q);
        for (int c = 0; c < 3; c++) begin
            xfer(1'b1, scrp_pkg::CFG_ADDR[c], 8'h00, q);
            chk("cfg_read", q, PAT[c] & 8'h3f);
            chk("cfg_out", {2'b00, chan_config_o[c]},
                PAT[c] & 8'h3f);
        end
    endtask : t_cfg
    task automatic t_stat;
        logic [7:0] q;
        @(posedge clk_i);
        status_flag_i <= 3'b101;
        for (int c = 0; c < 3; c++) begin
            xfer(1'b1, scrp_pkg::STAT_ADDR[c], 8'h00, q);
            chk("stat", q, {7'h00, c != 1});
        end
        xfer(1'b0, scrp_pkg::STAT_ADDR[0], 8'hff, q);
        xfer(1'b0, 5'h01, 8'hff, q);
        xfer(1'b1, 5'h00, 8'hff, q);
        chk("unmapped", q, 8'h00);
        xfer(1'b1, 5'h1f, 8'hff, q);
        chk("unmapped", q, 8'h00);
        for (int c = 0; c < 3; c++)
            chk("cfg_kept", {2'b00, chan_config_o[c]},
                PAT[c] & 8'h3f);
    endtask : t_stat
    task automatic t_irq;
        logic [7:0] q;
        wr(scrp_pkg::H_IRQ_MASK, 8'h03);
        wr(scrp_pkg::H_CMD, {3'b001, scrp_pkg::CFG_ADDR[1]});
        // second command while busy must be dropped
        wr(scrp_pkg::H_WDATA, 8'h00);
        wr(scrp_pkg::H_CMD, {3'b000, scrp_pkg::CFG_ADDR[0]});
        wait_idle();
        rd(scrp_pkg::H_RDATA, q);
        chk("rd_busy", q, PAT[1] & 8'h3f);
        chk("cfg0", {2'b00, chan_config_o[0]}, PAT[0] & 8'h3f);
        chk("irq", {7'h00, irq_o}, 8'h01);
        rd(scrp_pkg::H_IRQ_STAT, q);
        chk("irq_stat", q, 8'h03);
        wr(scrp_pkg::H_IRQ_STAT, 8'h03);
        rd(scrp_pkg::H_IRQ_STAT, q);
        chk("irq_clr", q, 8'h00);
        chk("irq", {7'h00, irq_o}, 8'h00);
        wr(scrp_pkg::H_IRQ_MASK, 8'h00);
        xfer(1'b1, scrp_pkg::STAT_ADDR[2], 8'h00, q);
        chk("irq_mask", {7'h00, irq_o}, 8'h00);
        rd(scrp_pkg::H_IRQ_STAT, q);
        chk("irq_stat", q, 8'h01);
        wr(scrp_pkg::H_IRQ_STAT, 8'h01);
    endtask : t_irq
    task automatic t_pin;
        logic [7:0] q;
        @(posedge clk_i);
        host_mode_select_i <= 1'b0;
        hw_config_i <= 6'h2d;
        repeat (10) @(posedge clk_i);
        for (int c = 0; c < 3; c++)
            chk("pin_cfg", {2'b00, chan_config_o[c]}, 8'h2d);
        // a serial write while in pin mode must not land
        xfer(1'b0, scrp_pkg::CFG_ADDR[2], 8'h00, q);
        @(posedge clk_i);
        host_mode_select_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        // back in host mode the registers keep the last pin setting
        chk("host_cfg", {2'b00, chan_config_o[2]}, 8'h2d);
        xfer(1'b1, scrp_pkg::CFG_ADDR[2], 8'h00, q);
        chk("host_read", q, 8'h2d);
    endtask : t_pin
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_cfg();
        t_stat();
        t_irq();
        t_pin();
        test_done();
    end
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule : tb_serial_command_register_port
`default_nettype wire
